// file: rtl/baud_gen_pkg.sv
package baud_gen_pkg;
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned DIV_WIDTH  = 16;
  localparam int unsigned FRAC_WIDTH = 3;
  localparam int unsigned MODE_WIDTH = 4;
  // Fixed prescale for the divided peripheral clock source.
  localparam int unsigned PRESCALE_DIV = 8;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [MODE_WIDTH-1:0] MODE_NORMAL     = 4'h0;
  localparam logic [MODE_WIDTH-1:0] MODE_SPI_MASTER = 4'he;
  localparam logic [MODE_WIDTH-1:0] MODE_SPI_SLAVE  = 4'hf;
  localparam logic [DIV_WIDTH-1:0]  DIV_RESET       = 16'h0000;
  localparam logic [3:0] OVER16_LAST = 4'hf;
  localparam logic [3:0] OVER8_LAST  = 4'h7;

  typedef enum logic [1:0] {
    SRC_PCLK     = 2'b00,
    SRC_PCLK_DIV = 2'b01,
    SRC_RSVD     = 2'b10,
    SRC_EXT      = 2'b11
  } clk_src_t;
endpackage : baud_gen_pkg

// file: rtl/ext_clk_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser and rising edge detector for the external serial clock.
module ext_clk_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Pin and result
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_pulse
);
  logic meta_q, sync_q, prev_q;
  logic meta_d, sync_d, prev_d;

  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level_out  = sync_q;
  assign rise_pulse = sync_q & ~prev_q;
endmodule : ext_clk_sync

// file: rtl/pin_sync2.sv
`timescale 1ns/10ps
// Plain two-flop synchroniser for a level pin.
module pin_sync2 (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Pin and result
  input  wire logic pin_in,
  output logic      level_out
);
  logic meta_q, sync_q;
  logic meta_d, sync_d;

  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  // Both pins idle high, so the flops reset to that level and no false edge follows reset.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign level_out = sync_q;
endmodule : pin_sync2

// file: rtl/serial_baud_rate_generator.sv
`timescale 1ns/10ps
// Operation
// - Source: peripheral, peripheral over eight, pin.
// - Source divided by 16-bit divisor.
// - Divisor zero produces no clock.
// - Divisor one passes source undivided.
// - Divided clock samples; bit clock further divided.
// - Ratio bit: eight else sixteen samples.
// - Bit rate is source over 8(2-over)divisor.
// - Nonzero fraction enables fractional division.
// - Fraction adds eighths to the divisor.
// - Fraction only in normal mode.
// - Clear-to-send low; slave select in slave.
// - Request-to-send low; slave select in master.
// - Data pins swap roles by SPI role.
// - Stopped clock resumes with state kept.
module serial_baud_rate_generator
  import baud_gen_pkg::*;
(
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 reset,
  // Configuration
  input  wire baud_gen_pkg::clk_src_t               clock_source_select,
  input  wire logic [baud_gen_pkg::DIV_WIDTH-1:0]   divisor_value,
  input  wire logic [baud_gen_pkg::FRAC_WIDTH-1:0]  fraction_value,
  input  wire logic [baud_gen_pkg::MODE_WIDTH-1:0]  port_mode,
  input  wire logic                                 over8_sel,
  // Serial clock pin
  input  wire logic                                 sck_in,
  // Handshake and data pins
  input  wire logic                                 cts_n_in,
  input  wire logic                                 rxd_in,
  output logic                                      rts_n_out,
  output logic                                      txd_out,
  // Core side
  input  wire logic                                 rts_req,
  input  wire logic                                 slave_select_req,
  input  wire logic                                 tx_bit,
  output logic                                      sample_tick,
  output logic                                      bit_tick,
  output logic                                      rx_bit,
  output logic                                      cts_active,
  output logic                                      slave_selected,
  output logic                                      mosi_sample,
  output logic                                      miso_sample
);
  import baud_gen_pkg::*;

  // Gating the module clock simply freezes every flop, so a restart resumes
  // exactly where counting stopped; no state is cleared on a clock stop.

  logic sck_level, sck_rise;
  logic cts_n_sync, rxd_sync;

  ext_clk_sync u_sck_sync (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .pin_in     (sck_in),
    .level_out  (sck_level),
    .rise_pulse (sck_rise)
  );

  pin_sync2 u_cts_sync (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .pin_in    (cts_n_in),
    .level_out (cts_n_sync)
  );

  pin_sync2 u_rxd_sync (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .pin_in    (rxd_in),
    .level_out (rxd_sync)
  );

  // Source selection.
  logic [2:0] pre_q, pre_d;
  logic       src_tick;

  always_comb begin
    pre_d = pre_q + 3'h1;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pre_q <= 3'h0;
    end else begin
      pre_q <= pre_d;
    end
  end

  always_comb begin
    unique case (clock_source_select)
      SRC_PCLK:     src_tick = 1'b1;
      SRC_PCLK_DIV: src_tick = (pre_q == PRESCALE_LAST);
      SRC_RSVD:     src_tick = 1'b1;
      SRC_EXT:      src_tick = sck_rise;
    endcase
  end

  // Main divider with optional eighth steps.
  logic                 spi_mode;
  logic                 frac_on;
  logic [DIV_WIDTH-1:0] cnt_q, cnt_d;
  logic [2:0]           phase_q, phase_d;
  logic                 stretch_q, stretch_d;
  logic                 div_tick;
  logic [3:0]           frac_sum;

  assign spi_mode = (port_mode == MODE_SPI_MASTER) || (port_mode == MODE_SPI_SLAVE);
  assign frac_on  = (fraction_value != 3'h0) && (port_mode == MODE_NORMAL);
  assign frac_sum = {1'b0, phase_q} + {1'b0, fraction_value};

  always_comb begin
    cnt_d     = cnt_q;
    phase_d   = phase_q;
    stretch_d = stretch_q;
    div_tick  = 1'b0;
    if (divisor_value == 16'h0000) begin
      cnt_d     = 16'h0000;
      stretch_d = 1'b0;
    end else if (src_tick) begin
      if (stretch_q) begin
        // One extra source period every time the eighths accumulate.
        stretch_d = 1'b0;
        cnt_d     = 16'h0000;
        div_tick  = 1'b1;
      end else if (cnt_q + 16'h0001 >= divisor_value) begin
        cnt_d = 16'h0000;
        if (frac_on) begin
          phase_d = frac_sum[2:0];
          if (frac_sum[3]) begin
            stretch_d = 1'b1;
          end else begin
            div_tick = 1'b1;
          end
        end else begin
          div_tick = 1'b1;
        end
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q     <= DIV_RESET;
      phase_q   <= 3'h0;
      stretch_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      phase_q   <= phase_d;
      stretch_q <= stretch_d;
    end
  end

  // Oversampling divider to the bit clock.
  logic [3:0] os_q, os_d;
  logic [3:0] os_last;
  logic       bit_d;

  assign os_last = over8_sel ? OVER8_LAST : OVER16_LAST;

  always_comb begin
    os_d  = os_q;
    bit_d = 1'b0;
    if (div_tick) begin
      if (os_q >= os_last) begin
        os_d  = 4'h0;
        bit_d = 1'b1;
      end else begin
        os_d = os_q + 4'h1;
      end
    end
  end

  logic samp_q, bit_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      os_q   <= 4'h0;
      samp_q <= 1'b0;
      bit_q  <= 1'b0;
    end else begin
      os_q   <= os_d;
      samp_q <= div_tick;
      bit_q  <= bit_d;
    end
  end

  assign sample_tick = samp_q;
  assign bit_tick    = bit_q;

  // Pin roles.
  logic slave_mode, master_mode;
  logic rts_n_q, rts_n_d, txd_q, txd_d;

  assign master_mode = (port_mode == MODE_SPI_MASTER);
  assign slave_mode  = (port_mode == MODE_SPI_SLAVE);

  always_comb begin
    rts_n_d = master_mode ? ~slave_select_req : ~rts_req;
    txd_d   = tx_bit;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rts_n_q <= 1'b1;
      txd_q   <= 1'b1;
    end else begin
      rts_n_q <= rts_n_d;
      txd_q   <= txd_d;
    end
  end

  assign rts_n_out      = rts_n_q;
  assign txd_out        = txd_q;
  assign cts_active     = ~slave_mode & ~cts_n_sync;
  assign slave_selected = slave_mode & ~cts_n_sync;
  assign rx_bit         = rxd_sync;
  assign miso_sample    = master_mode ? rxd_sync : 1'b0;
  assign mosi_sample    = slave_mode ? rxd_sync : 1'b0;

  // Assertions.
  // Watch the registered tick: a divisor written in the same cycle cannot trip it.
  a_zero_no_tick: assert property (@(posedge sys_clk) disable iff (reset)
    (divisor_value == 16'h0000) && $stable(divisor_value) |=> !sample_tick)
    else $error("divisor zero produced a sample tick");

  a_bypass_every: assert property (@(posedge sys_clk) disable iff (reset)
    (divisor_value == 16'h0001) && clock_source_select == SRC_PCLK && !frac_on
    && !stretch_q |-> div_tick)
    else $error("divisor one did not pass the source clock");

  // Code 2 runs at the full rate as well, so it may tick on every cycle.
  a_tick_single: assert property (@(posedge sys_clk) disable iff (reset)
    sample_tick && !(clock_source_select inside {SRC_PCLK, SRC_RSVD}) |=> !sample_tick)
    else $error("sample tick longer than one cycle");

  a_bit_from_samp: assert property (@(posedge sys_clk) disable iff (reset)
    bit_tick |-> sample_tick)
    else $error("bit tick without sample tick");

  // A carry left over from normal mode may still finish; no new one may start.
  a_frac_off_spi: assert property (@(posedge sys_clk) disable iff (reset)
    spi_mode && !stretch_q |=> !stretch_q)
    else $error("fraction active outside normal mode");

  a_rts_master: assert property (@(posedge sys_clk) disable iff (reset)
    master_mode && $stable(master_mode) |-> rts_n_out == ~$past(slave_select_req))
    else $error("slave select output wrong in master mode");

  a_rts_normal: assert property (@(posedge sys_clk) disable iff (reset)
    !master_mode && $stable(master_mode) && !$past(reset) |-> rts_n_out == ~$past(rts_req))
    else $error("request to send output wrong outside master mode");

  a_slave_sel: assert property (@(posedge sys_clk) disable iff (reset)
    slave_mode |-> !cts_active)
    else $error("clear to send active in slave mode");

  // A count left from 16x sampling may sit above seven until the next tick wraps it.
  a_over8_count: assert property (@(posedge sys_clk) disable iff (reset)
    over8_sel && div_tick |=> os_q <= OVER8_LAST)
    else $error("oversampling count exceeded eight");

  // The first cycle after reset still shows the reset level, so it is skipped.
  a_txd_follow: assert property (@(posedge sys_clk) disable iff (reset)
    !$past(reset) |-> txd_out == $past(tx_bit))
    else $error("transmit pin does not follow the core bit");

  a_sck_synced: assert property (@(posedge sys_clk) disable iff (reset)
    sck_rise |-> sck_level && $past(sck_in, 2) && !$past(sck_in, 3))
    else $error("serial clock edge taken without synchronisation");

  sequence s_frac_carry;
    frac_on && !stretch_q && src_tick && (divisor_value != 16'h0000)
    && (cnt_q + 16'h0001 >= divisor_value) && frac_sum[3];
  endsequence

  a_frac_carry: assert property (@(posedge sys_clk) disable iff (reset)
    s_frac_carry |-> !div_tick ##1 stretch_q)
    else $error("eighths carry did not add a source period");

  a_stretch_tick: assert property (@(posedge sys_clk) disable iff (reset)
    stretch_q && src_tick && (divisor_value != 16'h0000) |-> div_tick)
    else $error("stretched period ended without a tick");

  sequence s_prescaled_src;
    (clock_source_select == SRC_PCLK_DIV) [*8];
  endsequence

  a_prescale_period: assert property (@(posedge sys_clk) disable iff (reset)
    ((clock_source_select == SRC_PCLK_DIV) && src_tick) ##1 s_prescaled_src |-> src_tick)
    else $error("divided source tick not every eighth cycle");
endmodule : serial_baud_rate_generator

// file: test/remote_serial_dev.sv
`timescale 1ns/10ps
// Remote serial device on the clock, handshake and data pins.
module remote_serial_dev (
  // Clock
  input  wire logic sys_clk,
  // Bench control
  input  wire logic sck_run,
  input  wire logic cts_level,
  input  wire logic data_level,
  // Pins
  output logic      sck,
  output logic      cts_n,
  output logic      rxd
);
  logic [2:0] ph_q = 3'h0;
  // Three core cycles per phase keep the clock at a sixth of the core rate,
  // which is legal in every mode; the clock stands low outside frames.
  always @(posedge sys_clk) begin
    ph_q <= (!sck_run || ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
    sck  <= sck_run && (ph_q >= 3'h3);
  end
  assign cts_n = cts_level;
  assign rxd   = data_level;
endmodule : remote_serial_dev

// file: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import baud_gen_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  reset   = 1'b1;
  logic                  clk_run = 1'b1;
  clk_src_t              src     = SRC_PCLK;
  logic [DIV_WIDTH-1:0]  div     = 16'h0000;
  logic [FRAC_WIDTH-1:0] fp      = 3'h0;
  logic [MODE_WIDTH-1:0] mode    = MODE_NORMAL;
  logic                  over8   = 1'b0;
  logic                  sck_run = 1'b0;
  logic                  cts_lvl = 1'b1;
  logic                  rx_lvl  = 1'b1;
  logic                  rts_req = 1'b0;
  logic                  ss_req  = 1'b0;
  logic                  tx_bit  = 1'b1;
  logic                  sck, cts_n, rxd, rts_n_out, txd_out, sample_tick, bit_tick, rx_bit;
  logic                  cts_active, slave_selected, mosi_sample, miso_sample;
  logic [6:0]            exp_pins;
  logic [3:0]            modes [3] = '{MODE_NORMAL, MODE_SPI_MASTER, MODE_SPI_SLAVE};
  int                    n_errors = 0, total_checks = 0, cyc = 0, n_s, n_b, s0, b0;

  serial_baud_rate_generator serial_baud_rate_generator_i (
    .sys_clk(sys_clk), .reset(reset), .clock_source_select(src), .divisor_value(div),
    .fraction_value(fp), .port_mode(mode), .over8_sel(over8), .sck_in(sck),
    .cts_n_in(cts_n), .rxd_in(rxd), .rts_n_out(rts_n_out), .txd_out(txd_out),
    .rts_req(rts_req), .slave_select_req(ss_req), .tx_bit(tx_bit),
    .sample_tick(sample_tick), .bit_tick(bit_tick), .rx_bit(rx_bit),
    .cts_active(cts_active), .slave_selected(slave_selected),
    .mosi_sample(mosi_sample), .miso_sample(miso_sample));

  remote_serial_dev remote_serial_dev_i (
    .sys_clk(sys_clk), .sck_run(sck_run), .cts_level(cts_lvl), .data_level(rx_lvl),
    .sck(sck), .cts_n(cts_n), .rxd(rxd));

  // Clearing clk_run freezes the clock, standing in for a stopped peripheral clock.
  always #10 if (clk_run) sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Every divisor divides its source exactly, so the rate error stays at zero.
  // Divisors stay small so a counter left over from the last setting settles quickly.
  task automatic cfg(input clk_src_t s, input logic [15:0] d, input logic [2:0] f,
                     input logic [3:0] m, input logic o);
    @(posedge sys_clk);
    src   <= s;
    div   <= d;
    fp    <= f;
    mode  <= m;
    over8 <= o;
    repeat (64) @(posedge sys_clk);
  endtask : cfg

  // A window that spans whole periods holds an exact count whatever its phase.
  task automatic count(input int n);
    n_s = 0;
    n_b = 0;
    repeat (n) begin
      @(negedge sys_clk);
      n_s += (sample_tick === 1'b1);
      n_b += (bit_tick === 1'b1);
    end
  endtask : count

  initial begin
    repeat (8) @(posedge sys_clk);
    check(16'({rts_n_out, txd_out, sample_tick, bit_tick}), 16'h000c);
    reset <= 1'b0;
    cfg(SRC_PCLK, 16'h0002, 3'h0, MODE_NORMAL, 1'b1);
    count(80);
    s0 = n_s;
    b0 = n_b;
    clk_run = 1'b0;
    #195;
    clk_run = 1'b1;
    count(80);
    check(16'(s0 + n_s), 16'h0050);
    check(16'(b0 + n_b), 16'h000a);
    cfg(SRC_PCLK, 16'h0001, 3'h0, MODE_NORMAL, 1'b0);
    count(160);
    check(16'(n_s), 16'h00a0);
    check(16'(n_b), 16'h000a);
    cfg(SRC_PCLK, 16'h0000, 3'h0, MODE_NORMAL, 1'b0);
    count(160);
    check(16'(n_s + n_b), 16'h0000);
    cfg(SRC_PCLK_DIV, 16'h0001, 3'h0, MODE_NORMAL, 1'b1);
    count(320);
    check(16'(n_s), 16'h0028);
    check(16'(n_b), 16'h0005);
    cfg(SRC_RSVD, 16'h0004, 3'h0, MODE_NORMAL, 1'b0);
    count(160);
    check(16'(n_s), 16'h0028);
    cfg(SRC_PCLK, 16'h0002, 3'h4, MODE_NORMAL, 1'b1);
    count(160);
    check(16'(n_s), 16'h0040);
    check(16'(n_b), 16'h0008);
    cfg(SRC_PCLK, 16'h0002, 3'h4, MODE_SPI_MASTER, 1'b1);
    count(160);
    check(16'(n_s), 16'h0050);
    sck_run <= 1'b1;
    cfg(SRC_EXT, 16'h0001, 3'h0, MODE_NORMAL, 1'b1);
    count(336);
    check(16'(n_s), 16'h0038);
    check(16'(n_b), 16'h0007);
    sck_run <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      for (int k = 0; k < 32; k++) begin
        @(posedge sys_clk);
        mode    <= modes[i];
        cts_lvl <= k[0];
        rx_lvl  <= k[1];
        rts_req <= k[2];
        ss_req  <= k[3];
        tx_bit  <= k[4];
        exp_pins = {(i == 1) ? ~k[3] : ~k[2], k[4], k[1], (i != 2) & ~k[0],
                    (i == 2) & ~k[0], (i == 2) & k[1], (i == 1) & k[1]};
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check(16'({rts_n_out, txd_out, rx_bit, cts_active, slave_selected, mosi_sample,
                   miso_sample}), 16'(exp_pins));
      end
    end
    test_done();
  end
endmodule : tb_top
